// >>> logic/pms_top.sv
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module pms_top #(
    parameter int P250_CLKS = pms_pkg::CYC_250_CLKS,
    parameter int P500_CLKS = pms_pkg::CYC_500_CLKS,
    parameter int P1_CLKS = pms_pkg::CYC_1_CLKS,
    parameter int P2_CLKS = pms_pkg::CYC_2_CLKS,
    parameter int P4_CLKS = pms_pkg::CYC_4_CLKS
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic [1:0] avs_response_o,
    output logic avs_waitrequest_o,
    // drive side
    output logic sync0_o,
    output logic ctrl_update_o,
    output logic fse_o
);
    // ==================== bus handshake
    logic ack_r;
    logic [31:0] rdata_r;
    logic [1:0] resp_r;
    wire req = avs_read_i | avs_write_i;
    wire wr_go = avs_write_i & ack_r;
    wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                           {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign avs_waitrequest_o = req & ~ack_r;
    assign avs_readdata_o = rdata_r;
    assign avs_response_o = resp_r;

    // ==================== registers
    pms_pkg::pms_esm_t esm_r;
    logic [31:0] rx_assign_r;
    logic [31:0] tx_assign_r;
    logic [31:0] rx_cfg_r;
    logic [31:0] tx_cfg_r;
    logic [31:0] rx_fixed_r;
    logic [31:0] tx_fixed_r;
    logic [31:0] tx_extra_r;
    logic [31:0] sync_cfg_r;
    logic [31:0] abort_r;
    logic [31:0] lookup_r;
    logic [31:0] sync_count_r;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    wire [31:0] wdata_state = merge({28'h0, esm_r}, avs_writedata_i, be_mask);
    wire sel_state = wr_go & (avs_address_i == pms_pkg::OFS_STATE);
    wire sel_rx_assign = wr_go & (avs_address_i == pms_pkg::OFS_RX_ASSIGN);
    wire sel_tx_assign = wr_go & (avs_address_i == pms_pkg::OFS_TX_ASSIGN);
    wire sel_sdo = wr_go & (avs_address_i == pms_pkg::OFS_SDO_REQ);
    wire in_preop = (esm_r == pms_pkg::PMS_PREOP);
    wire assign_ok = in_preop; // [R8]
    wire assign_refused = (sel_rx_assign | sel_tx_assign) & ~in_preop;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            esm_r <= pms_pkg::PMS_INIT;
        end else if (sel_state) begin
            case (wdata_state[3:0])
                4'h1: esm_r <= pms_pkg::PMS_INIT;
                4'h2: esm_r <= pms_pkg::PMS_PREOP;
                4'h4: esm_r <= pms_pkg::PMS_SAFEOP;
                4'h8: esm_r <= pms_pkg::PMS_OP;
                default: esm_r <= esm_r;
            endcase
        end
    end

    // reset stands in for power-up; nothing here is kept across it [R9]
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rx_assign_r <= pms_pkg::RX_ASSIGN_RST; // [R10]
            tx_assign_r <= pms_pkg::TX_ASSIGN_RST; // [R10]
        end else begin
            if (sel_rx_assign && assign_ok) begin
                rx_assign_r <= merge(rx_assign_r, avs_writedata_i, be_mask); // [R5] [R8]
            end
            if (sel_tx_assign && assign_ok) begin
                tx_assign_r <= merge(tx_assign_r, avs_writedata_i, be_mask); // [R5] [R8]
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rx_cfg_r <= 32'h0;
            tx_cfg_r <= 32'h0;
            rx_fixed_r <= 32'h0;
            tx_fixed_r <= 32'h0;
            tx_extra_r <= 32'h0;
            sync_cfg_r <= pms_pkg::SYNC_CFG_RST;
            lookup_r <= 32'h0;
        end else if (wr_go) begin
            case (avs_address_i)
                pms_pkg::OFS_RX_CFG: rx_cfg_r <= merge(rx_cfg_r, avs_writedata_i, be_mask);
                pms_pkg::OFS_TX_CFG: tx_cfg_r <= merge(tx_cfg_r, avs_writedata_i, be_mask);
                pms_pkg::OFS_RX_FIXED: rx_fixed_r <= merge(rx_fixed_r, avs_writedata_i, be_mask);
                pms_pkg::OFS_TX_FIXED: tx_fixed_r <= merge(tx_fixed_r, avs_writedata_i, be_mask);
                pms_pkg::OFS_TX_EXTRA: tx_extra_r <= merge(tx_extra_r, avs_writedata_i, be_mask);
                pms_pkg::OFS_SYNC_CFG: sync_cfg_r <= merge(sync_cfg_r, avs_writedata_i, be_mask);
                pms_pkg::OFS_LOOKUP: lookup_r <= merge(lookup_r, avs_writedata_i, be_mask);
                default: lookup_r <= lookup_r;
            endcase
        end
    end

    // ==================== mapping checks
    function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction

    wire [15:0] rx_s1 = rx_assign_r[15:0];
    wire [15:0] rx_s2 = rx_assign_r[31:16];
    wire [15:0] tx_s1 = tx_assign_r[15:0];
    wire [15:0] tx_s2 = tx_assign_r[31:16];
    wire rx_f1 = in_rng(rx_s1, pms_pkg::MAP_RX_FIX_LO, pms_pkg::MAP_RX_FIX_HI);
    wire rx_f2 = in_rng(rx_s2, pms_pkg::MAP_RX_FIX_LO, pms_pkg::MAP_RX_FIX_HI);
    wire rx_c1 = (rx_s1 == pms_pkg::MAP_RX_CFG);
    wire rx_c2 = (rx_s2 == pms_pkg::MAP_RX_CFG);
    wire rx_n2 = (rx_s2 == pms_pkg::MAP_NONE);
    wire tx_f1 = in_rng(tx_s1, pms_pkg::MAP_TX_FIX_LO, pms_pkg::MAP_TX_FIX_HI);
    wire tx_f2 = in_rng(tx_s2, pms_pkg::MAP_TX_FIX_LO, pms_pkg::MAP_TX_FIX_HI);
    wire tx_c1 = (tx_s1 == pms_pkg::MAP_TX_CFG);
    wire tx_c2 = (tx_s2 == pms_pkg::MAP_TX_CFG);
    wire tx_e1 = (tx_s1 == pms_pkg::MAP_TX_EXTRA);
    wire tx_e2 = (tx_s2 == pms_pkg::MAP_TX_EXTRA);
    wire tx_n2 = (tx_s2 == pms_pkg::MAP_NONE);

    // single mapping allowed; a pair must be one of the listed sets
    wire rx_combo_ok = (rx_n2 & (rx_f1 | rx_c1)) | (rx_f1 & rx_c2) | (rx_c1 & rx_f2); // [R11]
    wire tx_combo_ok = (tx_n2 & (tx_f1 | tx_c1 | tx_e1))
                     | (tx_f1 & (tx_c2 | tx_e2)) | ((tx_c1 | tx_e1) & tx_f2)
                     | (tx_c1 & tx_e2) | (tx_e1 & tx_c2); // [R12]

    // per-mapping object count [3:0] and byte size [15:8]
    function automatic logic [4:0] m_cnt(input logic [15:0] idx, input logic [31:0] cfg,
                                         input logic [31:0] fix, input logic [31:0] ext,
                                         input logic [15:0] cfg_idx, input logic is_fix);
        m_cnt = 5'h0;
        if (idx == cfg_idx) m_cnt = {1'b0, cfg[3:0]};
        else if (is_fix) m_cnt = {1'b0, fix[3:0]};
        else if (idx == pms_pkg::MAP_TX_EXTRA) m_cnt = {1'b0, ext[3:0]};
    endfunction

    function automatic logic [8:0] m_len(input logic [15:0] idx, input logic [31:0] cfg,
                                         input logic [31:0] fix, input logic [31:0] ext,
                                         input logic [15:0] cfg_idx, input logic is_fix);
        m_len = 9'h0;
        if (idx == cfg_idx) m_len = {1'b0, cfg[15:8]};
        else if (is_fix) m_len = {1'b0, fix[15:8]};
        else if (idx == pms_pkg::MAP_TX_EXTRA) m_len = {1'b0, ext[15:8]};
    endfunction

    wire [4:0] rx_cnt1 = m_cnt(rx_s1, rx_cfg_r, rx_fixed_r, 32'h0, pms_pkg::MAP_RX_CFG, rx_f1);
    wire [4:0] rx_cnt2 = m_cnt(rx_s2, rx_cfg_r, rx_fixed_r, 32'h0, pms_pkg::MAP_RX_CFG, rx_f2);
    wire [8:0] rx_len1 = m_len(rx_s1, rx_cfg_r, rx_fixed_r, 32'h0, pms_pkg::MAP_RX_CFG, rx_f1);
    wire [8:0] rx_len2 = m_len(rx_s2, rx_cfg_r, rx_fixed_r, 32'h0, pms_pkg::MAP_RX_CFG, rx_f2);
    wire [4:0] tx_cnt1 = m_cnt(tx_s1, tx_cfg_r, tx_fixed_r, tx_extra_r, pms_pkg::MAP_TX_CFG, tx_f1);
    wire [4:0] tx_cnt2 = m_cnt(tx_s2, tx_cfg_r, tx_fixed_r, tx_extra_r, pms_pkg::MAP_TX_CFG, tx_f2);
    wire [8:0] tx_len1 = m_len(tx_s1, tx_cfg_r, tx_fixed_r, tx_extra_r, pms_pkg::MAP_TX_CFG, tx_f1);
    wire [8:0] tx_len2 = m_len(tx_s2, tx_cfg_r, tx_fixed_r, tx_extra_r, pms_pkg::MAP_TX_CFG, tx_f2);
    wire [4:0] rx_cnt_sum = 5'(rx_cnt1 + rx_cnt2);
    wire [4:0] tx_cnt_sum = 5'(tx_cnt1 + tx_cnt2);
    wire [8:0] tx_len_sum = 9'(tx_len1 + tx_len2);
    wire rx_cfg_used = rx_c1 | rx_c2;
    wire tx_cfg_used = tx_c1 | tx_c2;

    wire rx_cfg_cnt_bad = rx_cfg_used & ({1'b0, rx_cfg_r[3:0]} > pms_pkg::RX_CFG_MAX_OBJ); // [R1]
    wire rx_cfg_len_bad = rx_cfg_used & ({1'b0, rx_cfg_r[15:8]} > pms_pkg::RX_CFG_MAX_BYTES); // [R1]
    wire tx_cfg_cnt_bad = tx_cfg_used & ({1'b0, tx_cfg_r[3:0]} > pms_pkg::TX_CFG_MAX_OBJ); // [R1]
    wire tx_len_bad = tx_cfg_used & (tx_len_sum > pms_pkg::TX_MAX_BYTES); // [R2]
    wire rx_tot_bad = rx_cnt_sum > pms_pkg::RX_TOTAL_MAX_OBJ; // [R13]
    wire tx_tot_bad = tx_cnt_sum > pms_pkg::TX_TOTAL_MAX_OBJ; // [R14]
    wire size_err = rx_cfg_len_bad | tx_len_bad; // [R3]
    wire count_err = rx_cfg_cnt_bad | tx_cfg_cnt_bad | rx_tot_bad | tx_tot_bad; // [R4]
    wire combo_err = ~rx_combo_ok | ~tx_combo_ok;

    // second mapping starts right after the first [R6]
    wire [7:0] rx_off2 = rx_len1[7:0];
    wire [7:0] tx_off2 = tx_len1[7:0];

    // duplicates: sub-index 02 is laid out later, so it wins [R7]
    wire [1:0] lookup_src = lookup_r[17] ? 2'h2 : (lookup_r[16] ? 2'h1 : 2'h0);

    // ==================== sync0 generation
    logic [pms_pkg::SYNC_CNT_W-1:0] sync_div_r;
    logic sync0_r;
    wire [2:0] cyc_sel = sync_cfg_r[2:0];
    wire gear_unity = sync_cfg_r[8];
    wire sync_en = sync_cfg_r[9];
    wire cyc_valid = (cyc_sel <= pms_pkg::SEL_4); // [R20]
    wire short_cyc = (cyc_sel == pms_pkg::SEL_250) | (cyc_sel == pms_pkg::SEL_500);
    wire gear_err = short_cyc & ~gear_unity; // [R22]
    wire fse = size_err | count_err | gear_err | combo_err | ~cyc_valid;
    wire [pms_pkg::SYNC_CNT_W-1:0] period_m1 =
        (cyc_sel == pms_pkg::SEL_250) ? pms_pkg::SYNC_CNT_W'(P250_CLKS - 1) :
        (cyc_sel == pms_pkg::SEL_500) ? pms_pkg::SYNC_CNT_W'(P500_CLKS - 1) :
        (cyc_sel == pms_pkg::SEL_1) ? pms_pkg::SYNC_CNT_W'(P1_CLKS - 1) :
        (cyc_sel == pms_pkg::SEL_2) ? pms_pkg::SYNC_CNT_W'(P2_CLKS - 1) :
        pms_pkg::SYNC_CNT_W'(P4_CLKS - 1);
    wire sync_run = sync_en & cyc_valid;
    wire sync_hit = sync_run & (sync_div_r >= period_m1);

    // free-running timebase; a changed period keeps the count, a disable or an invalid cycle selection restarts it from zero
    always_ff @(posedge clock_i) begin
        if (rst_i || !sync_run) begin
            sync_div_r <= '0;
        end else if (sync_hit) begin
            sync_div_r <= '0; // [R21]
        end else begin
            sync_div_r <= sync_div_r + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync0_r <= 1'b0;
            sync_count_r <= 32'h0;
        end else begin
            sync0_r <= sync_hit; // [R21]
            if (sync_hit) begin
                sync_count_r <= sync_count_r + 32'h1;
            end
        end
    end
    assign sync0_o = sync0_r;
    // control update fires on each sync0 event unless configuration is faulty
    assign ctrl_update_o = sync0_r & ~fse; // [R21]
    assign fse_o = fse; // [R3] [R4] [R22]

    // ==================== sdo abort evaluation
    wire [11:0] q = avs_writedata_i[11:0];
    // q: 0 write, 1 exists, 2 sub exists, 3 readable, 4 writable, 5 mappable,
    // 6 overflow, 7 above max, 8 below min, 9 toggle err, 10 timeout, 11 assign
    logic [31:0] abort_nxt;
    always_comb begin
        abort_nxt = pms_pkg::AB_NONE;
        if (q[10]) abort_nxt = pms_pkg::AB_TIMEOUT; // [R19]
        else if (q[9]) abort_nxt = pms_pkg::AB_TOGGLE; // [R19]
        else if (!q[1]) abort_nxt = pms_pkg::AB_NO_OBJECT; // [R16]
        else if (!q[2]) abort_nxt = pms_pkg::AB_NO_SUBINDEX; // [R16]
        else if (q[0] && q[11] && !in_preop) abort_nxt = pms_pkg::AB_DEV_STATE; // [R23]
        else if (!q[0] && !q[3]) abort_nxt = pms_pkg::AB_WRITE_ONLY; // [R15]
        else if (q[0] && !q[4]) abort_nxt = pms_pkg::AB_READ_ONLY; // [R15]
        else if (q[0] && q[11] && !q[5]) abort_nxt = pms_pkg::AB_NOT_MAPPABLE; // [R17]
        else if (q[0] && q[11] && q[6]) abort_nxt = pms_pkg::AB_MAP_LENGTH; // [R17]
        else if (q[0] && q[7]) abort_nxt = pms_pkg::AB_TOO_HIGH; // [R18]
        else if (q[0] && q[8]) abort_nxt = pms_pkg::AB_TOO_LOW; // [R18]
    end

    // a refused assignment write overrides an sdo evaluation in the same cycle
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            abort_r <= pms_pkg::AB_NONE;
        end else if (assign_refused) begin
            abort_r <= pms_pkg::AB_DEV_STATE; // [R23]
        end else if (sel_sdo) begin
            abort_r <= abort_nxt;
        end
    end

    // ==================== read mux
    wire [31:0] status_w = {(fse ? pms_pkg::FSE_CODE : 16'h0000), 10'h0,
                            ~cyc_valid, gear_err, combo_err, count_err, size_err, fse};
    logic [31:0] rmux;
    logic hit;
    always_comb begin
        rmux = 32'h0;
        hit = 1'b1;
        case (avs_address_i)
            pms_pkg::OFS_STATE: rmux = {28'h0, esm_r};
            pms_pkg::OFS_RX_ASSIGN: rmux = rx_assign_r;
            pms_pkg::OFS_TX_ASSIGN: rmux = tx_assign_r;
            pms_pkg::OFS_RX_CFG: rmux = rx_cfg_r;
            pms_pkg::OFS_TX_CFG: rmux = tx_cfg_r;
            pms_pkg::OFS_RX_FIXED: rmux = rx_fixed_r;
            pms_pkg::OFS_TX_FIXED: rmux = tx_fixed_r;
            pms_pkg::OFS_TX_EXTRA: rmux = tx_extra_r;
            pms_pkg::OFS_SYNC_CFG: rmux = sync_cfg_r;
            pms_pkg::OFS_STATUS: rmux = status_w;
            pms_pkg::OFS_SDO_REQ: rmux = 32'h0;
            pms_pkg::OFS_SDO_ABORT: rmux = abort_r;
            pms_pkg::OFS_SYNC_COUNT: rmux = sync_count_r;
            pms_pkg::OFS_LOOKUP: rmux = {lookup_r[31:20], lookup_src, lookup_r[17:0]};
            pms_pkg::OFS_LAYOUT: rmux = {16'h0, tx_off2, rx_off2};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
            resp_r <= 2'h0;
        end else begin
            ack_r <= req & ~ack_r;
            if (req && !ack_r) begin
                rdata_r <= avs_read_i ? rmux : 32'h0;
                resp_r <= hit ? 2'h0 : 2'h2;
            end
        end
    end
endmodule

// >>> logic/pms_pkg.sv
// Function
// R1: configurable rx max 10 objects/24 bytes; tx 10
// R2: combined tx with configurable one max 30 bytes
// R3: oversize mapping raises function setting error 93.4
// R4: too many objects raises error 93.4
// R5: up to two mappings per direction assigned
// R6: sub-index 01 laid out before 02
// R7: duplicate object takes last occurrence value
// R8: assignment changes accepted only in pre-operational
// R9: mappings volatile; master rewrites after power-up
// R10: power-up defaults rx 1701, tx 1B01
// R11: rx pair: fixed 1701..1705 plus 1600
// R12: tx pairs: fixed+1A00, fixed+1BFF, 1A00+1BFF
// R13: combined rx at most 10 objects
// R14: combined tx at most 11 objects
// R15: read write-only/write read-only abort codes
// R16: absent object or sub-index abort codes
// R17: non-mappable or length overflow abort codes
// R18: value too high/too low abort codes
// R19: toggle error and timeout abort codes
// R20: cycle equals Sync0 period, five choices
// R21: sync0 events at exact intervals drive control
// R22: short cycles need gear 1:1 else 93.4
// R23: assignment write outside pre-op aborts, state
package pms_pkg;
    // ==================== register offsets
    localparam logic [7:0] OFS_STATE = 8'h00;
    localparam logic [7:0] OFS_RX_ASSIGN = 8'h04;
    localparam logic [7:0] OFS_TX_ASSIGN = 8'h08;
    localparam logic [7:0] OFS_RX_CFG = 8'h0C;
    localparam logic [7:0] OFS_TX_CFG = 8'h10;
    localparam logic [7:0] OFS_RX_FIXED = 8'h14;
    localparam logic [7:0] OFS_TX_FIXED = 8'h18;
    localparam logic [7:0] OFS_TX_EXTRA = 8'h1C;
    localparam logic [7:0] OFS_SYNC_CFG = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_SDO_REQ = 8'h28;
    localparam logic [7:0] OFS_SDO_ABORT = 8'h2C;
    localparam logic [7:0] OFS_SYNC_COUNT = 8'h30;
    localparam logic [7:0] OFS_LOOKUP = 8'h34;
    localparam logic [7:0] OFS_LAYOUT = 8'h38;
    // ==================== fieldbus state
    typedef enum logic [3:0] {
        PMS_INIT = 4'h1,
        PMS_PREOP = 4'h2,
        PMS_SAFEOP = 4'h4,
        PMS_OP = 4'h8
    } pms_esm_t;
    // ==================== mapping indexes
    localparam logic [15:0] MAP_NONE = 16'h0000;
    localparam logic [15:0] MAP_RX_CFG = 16'h1600;
    localparam logic [15:0] MAP_RX_FIX_LO = 16'h1701;
    localparam logic [15:0] MAP_RX_FIX_HI = 16'h1705;
    localparam logic [15:0] MAP_TX_CFG = 16'h1A00;
    localparam logic [15:0] MAP_TX_FIX_LO = 16'h1B01;
    localparam logic [15:0] MAP_TX_FIX_HI = 16'h1B04;
    localparam logic [15:0] MAP_TX_EXTRA = 16'h1BFF;
    localparam logic [31:0] RX_ASSIGN_RST = {MAP_NONE, MAP_RX_FIX_LO};
    localparam logic [31:0] TX_ASSIGN_RST = {MAP_NONE, MAP_TX_FIX_LO};
    // ==================== limits
    localparam logic [4:0] RX_CFG_MAX_OBJ = 5'h0A;
    localparam logic [8:0] RX_CFG_MAX_BYTES = 9'h018;
    localparam logic [4:0] TX_CFG_MAX_OBJ = 5'h0A;
    localparam logic [8:0] TX_MAX_BYTES = 9'h01E;
    localparam logic [4:0] RX_TOTAL_MAX_OBJ = 5'h0A;
    localparam logic [4:0] TX_TOTAL_MAX_OBJ = 5'h0B;
    localparam logic [15:0] FSE_CODE = 16'h0934;
    // ==================== abort codes
    localparam logic [31:0] AB_NONE = 32'h0000_0000;
    localparam logic [31:0] AB_TOGGLE = 32'h0503_0000;
    localparam logic [31:0] AB_TIMEOUT = 32'h0504_0000;
    localparam logic [31:0] AB_WRITE_ONLY = 32'h0601_0001;
    localparam logic [31:0] AB_READ_ONLY = 32'h0601_0002;
    localparam logic [31:0] AB_NO_OBJECT = 32'h0602_0000;
    localparam logic [31:0] AB_NOT_MAPPABLE = 32'h0604_0041;
    localparam logic [31:0] AB_MAP_LENGTH = 32'h0604_0042;
    localparam logic [31:0] AB_NO_SUBINDEX = 32'h0609_0011;
    localparam logic [31:0] AB_TOO_HIGH = 32'h0609_0031;
    localparam logic [31:0] AB_TOO_LOW = 32'h0609_0032;
    localparam logic [31:0] AB_DEV_STATE = 32'h0800_0022;
    // ==================== sync0 timing
    localparam int CLK_MHZ = 125;
    localparam int CYC_250_US = 250;
    localparam int CYC_500_US = 500;
    localparam int CYC_1_MS = 1;
    localparam int CYC_2_MS = 2;
    localparam int CYC_4_MS = 4;
    localparam int CYC_250_CLKS = CYC_250_US * CLK_MHZ;
    localparam int CYC_500_CLKS = CYC_500_US * CLK_MHZ;
    localparam int CYC_1_CLKS = CYC_1_MS * 1000 * CLK_MHZ;
    localparam int CYC_2_CLKS = CYC_2_MS * 1000 * CLK_MHZ;
    localparam int CYC_4_CLKS = CYC_4_MS * 1000 * CLK_MHZ;
    localparam int SYNC_CNT_W = 19;
    localparam logic [2:0] SEL_250 = 3'h0;
    localparam logic [2:0] SEL_500 = 3'h1;
    localparam logic [2:0] SEL_1 = 3'h2;
    localparam logic [2:0] SEL_2 = 3'h3;
    localparam logic [2:0] SEL_4 = 3'h4;
    localparam logic [31:0] SYNC_CFG_RST = 32'h0000_0002;
endpackage

// >>> tb/pms_checker.sv
`timescale 1ns/1ps
module pms_checker (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // bus handshake
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    // drive side
    input wire logic sync0_o,
    input wire logic ctrl_update_o,
    input wire logic fse_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // ==================== bus
    a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("wait lasted more than one cycle");
    a_idle_no_wait: assert property (!(avs_read_i || avs_write_i)
        |-> !avs_waitrequest_o) else $error("wait raised with no request");
    // ==================== sync and errors
    a_update_on_sync: assert property (ctrl_update_o |-> sync0_o && !fse_o)
        else $error("update without clean sync");
    a_sync_drives_update: assert property (sync0_o && !fse_o |-> ctrl_update_o)
        else $error("sync without update");
    a_update_pulse: assert property (ctrl_update_o |=> !ctrl_update_o)
        else $error("update longer than a cycle");
    a_sync_gap: assert property (sync0_o |=> !sync0_o [*8])
        else $error("sync events too close");
    a_fse_by_write: assert property ($changed(fse_o)
        |-> $past(avs_write_i && !avs_waitrequest_o)) else $error("error flag moved without a write");
    a_reset_quiet: assert property ($fell(rst_i) |-> !sync0_o [*4])
        else $error("sync right after reset");
    c_update: cover property (ctrl_update_o);
    c_sync_blocked: cover property (sync0_o && fse_o);
    c_write_done: cover property (avs_write_i && !avs_waitrequest_o);
endmodule
bind pms_top pms_checker chk_i (.clock_i(clock_i), .rst_i(rst_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .sync0_o(sync0_o),
    .ctrl_update_o(ctrl_update_o), .fse_o(fse_o));

// >>> tb/pms_master_model.sv
`timescale 1ns/1ps
module pms_master_model (
    // clock
    input wire logic clock_i,
    // slave answer
    input wire logic waitrequest_i,
    input wire logic [31:0] readdata_i,
    input wire logic [1:0] response_i,
    // request
    output logic [7:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] writedata_o,
    output logic [3:0] byteenable_o
);
    initial begin
        address_o = 8'h00;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h0;
        byteenable_o = 4'hF;
    end
    // a fresh edge first, so two calls never assign one strobe in one step
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        address_o <= a;
        writedata_o <= d;
        write_o <= 1'b1;
        @(posedge clock_i);
        while (waitrequest_i) @(posedge clock_i);
        write_o <= 1'b0;
        writedata_o <= ~d;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock_i);
        address_o <= a;
        read_o <= 1'b1;
        @(posedge clock_i);
        while (waitrequest_i) @(posedge clock_i);
        d = readdata_i;
        r = response_i;
        read_o <= 1'b0;
        address_o <= ~a;
    endtask
endmodule

// >>> tb/pdo_mapping_sdo_abort_sync_bench.sv
`timescale 1ns/1ps
module pdo_mapping_sdo_abort_sync_bench;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr;
    logic rd;
    logic wr;
    logic [31:0] wdat;
    logic [3:0] be;
    logic [31:0] rdat;
    logic [1:0] resp;
    logic waitreq;
    logic sync0;
    logic upd;
    logic fse;
    logic [31:0] q;
    logic [1:0] rs;
    int bad_count = 0;
    int tests_run = 0;
    int per [5] = '{10, 20, 40, 80, 160};
    logic [40:0] mt [20] = '{
        {pms_pkg::OFS_STATE, 32'h2, 1'b0},
        {pms_pkg::OFS_RX_FIXED, 32'h0804, 1'b0},
        {pms_pkg::OFS_RX_ASSIGN, pms_pkg::MAP_RX_CFG, 16'h1702, 1'b0},
        {pms_pkg::OFS_RX_CFG, 32'h1006, 1'b0},
        {pms_pkg::OFS_RX_CFG, 32'h1007, 1'b1},
        {pms_pkg::OFS_RX_FIXED, 32'h0, 1'b0},
        {pms_pkg::OFS_RX_CFG, 32'h180A, 1'b0},
        {pms_pkg::OFS_RX_CFG, 32'h190A, 1'b1},
        {pms_pkg::OFS_RX_CFG, 32'h180B, 1'b1},
        {pms_pkg::OFS_RX_CFG, 32'h1006, 1'b0},
        {pms_pkg::OFS_RX_ASSIGN, pms_pkg::MAP_TX_CFG, 16'h1702, 1'b1},
        {pms_pkg::OFS_RX_ASSIGN, pms_pkg::MAP_RX_CFG, 16'h1702, 1'b0},
        {pms_pkg::OFS_TX_FIXED, 32'h1005, 1'b0},
        {pms_pkg::OFS_TX_ASSIGN, pms_pkg::MAP_TX_CFG, 16'h1B01, 1'b0},
        {pms_pkg::OFS_TX_CFG, 32'h0E06, 1'b0},
        {pms_pkg::OFS_TX_CFG, 32'h0F06, 1'b1},
        {pms_pkg::OFS_TX_CFG, 32'h0E07, 1'b1},
        {pms_pkg::OFS_TX_ASSIGN, 32'h1B021B01, 1'b1},
        {pms_pkg::OFS_TX_ASSIGN, 32'h1BFF1B04, 1'b0},
        {pms_pkg::OFS_TX_ASSIGN, 32'h1BFF1A00, 1'b0}};
    logic [63:0] st [11] = '{
        {32'h036, pms_pkg::AB_WRITE_ONLY}, {32'h02F, pms_pkg::AB_READ_ONLY},
        {32'h03C, pms_pkg::AB_NO_OBJECT}, {32'h03A, pms_pkg::AB_NO_SUBINDEX},
        {32'h81F, pms_pkg::AB_NOT_MAPPABLE}, {32'h87F, pms_pkg::AB_MAP_LENGTH},
        {32'h0BF, pms_pkg::AB_TOO_HIGH}, {32'h13F, pms_pkg::AB_TOO_LOW},
        {32'h23E, pms_pkg::AB_TOGGLE}, {32'h63E, pms_pkg::AB_TIMEOUT},
        {32'h03E, pms_pkg::AB_NONE}};
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    pms_top #(.P250_CLKS(10), .P500_CLKS(20), .P1_CLKS(40), .P2_CLKS(80), .P4_CLKS(160)) DUT (
        .clock_i(clock_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_response_o(resp), .avs_waitrequest_o(waitreq),
        .sync0_o(sync0), .ctrl_update_o(upd), .fse_o(fse));
    pms_master_model mdl (.clock_i(clock_i), .waitrequest_i(waitreq), .readdata_i(rdat),
        .response_i(resp), .address_o(adr), .read_o(rd), .write_o(wr), .writedata_o(wdat),
        .byteenable_o(be));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        mdl.rd(a, q, rs);
        chk("register", q, e);
    endtask
    task wf(input logic [7:0] a, input logic [31:0] d, input logic e);
        mdl.wr(a, d);
        @(negedge clock_i);
        chk("error flag", {31'h0, fse}, {31'h0, e});
    endtask
    // measures the gap between two sync events and the update seen with the second
    task sp(input logic [31:0] cfg, input int p, input logic e);
        int n;
        wf(pms_pkg::OFS_SYNC_CFG, cfg, e);
        do @(negedge clock_i); while (!sync0);
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (!sync0);
        chk("period", n, p);
        chk("update", {31'h0, upd}, {31'h0, !e});
    endtask
    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        rchk(pms_pkg::OFS_RX_ASSIGN, pms_pkg::RX_ASSIGN_RST);
        rchk(pms_pkg::OFS_TX_ASSIGN, pms_pkg::TX_ASSIGN_RST);
        mdl.rd(8'hFC, q, rs);
        chk("response", {30'h0, rs}, 32'h2);
        for (int i = 0; i < 5; i++) sp(32'h300 | i, per[i], 1'b0);
        sp(32'h200, 10, 1'b1);
        sp(32'h202, 40, 1'b0);
        wf(pms_pkg::OFS_SYNC_CFG, 32'h5, 1'b1);
        wf(pms_pkg::OFS_SYNC_CFG, 32'h2, 1'b0);
        wf(pms_pkg::OFS_STATE, 32'h1, 1'b0);
        mdl.wr(pms_pkg::OFS_RX_ASSIGN, 32'h16001702);
        rchk(pms_pkg::OFS_RX_ASSIGN, pms_pkg::RX_ASSIGN_RST);
        rchk(pms_pkg::OFS_SDO_ABORT, pms_pkg::AB_DEV_STATE);
        foreach (mt[i]) wf(mt[i][40:33], mt[i][32:1], mt[i][0]);
        // fixed rx mapping needs a size again so its offset shows in the layout
        mdl.wr(pms_pkg::OFS_RX_FIXED, 32'h0804);
        mdl.wr(pms_pkg::OFS_TX_ASSIGN, 32'h1A001B01);
        rchk(pms_pkg::OFS_LAYOUT, 32'h1008);
        rchk(pms_pkg::OFS_STATUS, {pms_pkg::FSE_CODE, 16'h0005});
        mdl.wr(pms_pkg::OFS_LOOKUP, 32'h30000);
        rchk(pms_pkg::OFS_LOOKUP, 32'hB0000);
        mdl.wr(pms_pkg::OFS_LOOKUP, 32'h10000);
        rchk(pms_pkg::OFS_LOOKUP, 32'h50000);
        foreach (st[i]) begin
            mdl.wr(pms_pkg::OFS_SDO_REQ, st[i][63:32]);
            rchk(pms_pkg::OFS_SDO_ABORT, st[i][31:0]);
        end
        // power cycle loses the mapping, so the master must write it again
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        rchk(pms_pkg::OFS_RX_ASSIGN, pms_pkg::RX_ASSIGN_RST);
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        final_report;
    end
endmodule
